// ===== logic/pulse_count_register_writer.sv
// Pulse-count register writer: decodes address and data bursts on one line
// Assumes a 20 MHz clock; the line comes straight from a pin
//
// Notes on behaviour
// [R1] Write-only link; address space of 32 registers; nothing is ever read back.
// [R2] Line high longer than wake time enables the device.
// [R3] Line low longer than shutdown time disables the device.
// [R4] First burst count 0..31 latched as address after address hold.
// [R5] No hold: keep counting; above 31 drop write, reset at next hold.
// [R6] High beyond maximum address hold resets bus; next burst is address.
// [R7] Second burst counts data 0..63, a 6-bit value.
// [R8] Data accepted after data hold; above 63 drops write and resets.
// [R9] Completed data hold stores data into the addressed register.
// [R10] After data hold next burst is an address; no upper hold limit.
// [R11] Host sends an address before every data burst.
// [R12] Back-to-back pairs need only the data hold between them.
// [R13] High for 10 ms after transfer returns to standby, bus reset.
// [R14] Host keeps pulse widths below minimum address hold.
// [R15] Five write-only registers, all reset to zero.
// [R16] Host writes zero to unused upper bits.
// [R17] Register 01h: four sink enable bits in bits 3..0.
// [R18] Register 02h: 4-bit code; register 03h: 3-bit code.
// [R19] Register 04h: ramp rate in bits 2..1, ramp enable bit 0.
// [R20] Shutdown returns every register to its reset value.
// [R21] Durations are cycle counts against parameterised thresholds.
`timescale 1ns/100ps
`default_nettype none
module pulse_count_register_writer
    import pulse_pkg::*;
#(
    parameter int WAKE_CYCLES = pulse_pkg::WAKE_CYC,
    parameter int SHUT_CYCLES = pulse_pkg::SHUT_CYC,
    parameter int HOLDA_MIN_CYCLES = pulse_pkg::HOLDA_MIN_CYC,
    parameter int HOLDA_MAX_CYCLES = pulse_pkg::HOLDA_MAX_CYC,
    parameter int HOLDD_CYCLES = pulse_pkg::HOLDD_CYC,
    parameter int STANDBY_CYCLES = pulse_pkg::STANDBY_CYC
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic pulseLine,
    output logic deviceEnabled,
    output logic standby,
    output logic [4:0] sinkCurrentCode,
    output logic [3:0] sinkEnableBits,
    output logic [3:0] regulator1VoltageCode,
    output logic [2:0] regulator2VoltageCode,
    output logic [1:0] rampRate,
    output logic rampEnable
);
    import pulse_pkg::*;

    localparam logic [TW-1:0] T_WAKE = TW'(WAKE_CYCLES);
    localparam logic [TW-1:0] T_SHUT = TW'(SHUT_CYCLES);
    localparam logic [TW-1:0] T_HAMIN = TW'(HOLDA_MIN_CYCLES);
    localparam logic [TW-1:0] T_HAMAX = TW'(HOLDA_MAX_CYCLES);
    localparam logic [TW-1:0] T_HD = TW'(HOLDD_CYCLES);
    localparam logic [TW-1:0] T_SB = TW'(STANDBY_CYCLES);
    localparam logic [TW-1:0] T_TOP = {TW{1'b1}};
    localparam logic [CW-1:0] CNT_TOP = {CW{1'b1}};
    localparam logic [CW-1:0] ONE_C = 7'h01;
    localparam logic [TW-1:0] ONE_T = 18'h00001;

    pulse_line_if ev ();

    pulse_line_sync u_sync (
        .clock(clock),
        .rst(rst),
        .pulseLine(pulseLine),
        .ev(ev)
    );

    typedef struct packed {
        phase_t phase;
        logic [TW-1:0] hiCnt;
        logic [TW-1:0] loCnt;
        logic [CW-1:0] edges;
        logic [AW-1:0] addr;
        logic held;
        logic busy;
        logic sb;
        logic [4:0][DW-1:0] regs;
    } state_t;

    state_t st_q, st_d;
    logic writeStrobe;

    always_comb begin
        st_d = st_q;
        writeStrobe = 1'b0;
        // Time the current level; counters saturate rather than wrap
        if (ev.rise || ev.fall) begin
            st_d.hiCnt = '0;
            st_d.loCnt = '0;
        end else if (ev.level) begin
            if (st_q.hiCnt != T_TOP) begin
                st_d.hiCnt = st_q.hiCnt + ONE_T;
            end
        end else begin
            if (st_q.loCnt != T_TOP) begin
                st_d.loCnt = st_q.loCnt + ONE_T;
            end
        end
        case (st_q.phase)
            S_OFF: begin
                st_d.edges = '0;
                st_d.held = 1'b0;
                st_d.busy = 1'b0;
                st_d.sb = 1'b1;
                // Wake needs a sustained high, not a glitch
                if (ev.level && st_q.hiCnt >= T_WAKE) begin // [R2] [R21]
                    st_d.phase = S_ADDR;
                end
            end
            S_ADDR: begin
                if (ev.rise) begin
                    st_d.busy = 1'b1;
                    st_d.sb = 1'b0;
                    st_d.held = 1'b0;
                    if (st_q.edges != CNT_TOP) begin
                        st_d.edges = st_q.edges + ONE_C; // [R4] [R5]
                    end
                end
                if (ev.level && st_q.busy && !st_q.held && st_q.hiCnt == T_HAMIN) begin
                    st_d.held = 1'b1;
                    if (st_q.edges > ADDR_LIMIT) begin
                        st_d.edges = '0; // [R5]
                        st_d.busy = 1'b0;
                        st_d.held = 1'b0;
                    end
                end
                // Data burst starts; address taken from the held count
                if (ev.fall && st_q.held) begin
                    st_d.addr = AW'(st_q.edges - ONE_C); // [R4]
                    st_d.edges = '0;
                    st_d.held = 1'b0;
                    st_d.phase = S_DATA; // [R7]
                end
                if (ev.level && st_q.held && st_q.hiCnt == T_HAMAX) begin
                    st_d.edges = '0; // [R6]
                    st_d.held = 1'b0;
                    st_d.busy = 1'b0;
                    st_d.phase = S_ADDR;
                end
            end
            S_DATA: begin
                if (ev.rise) begin
                    st_d.held = 1'b0;
                    if (st_q.edges != CNT_TOP) begin
                        st_d.edges = st_q.edges + ONE_C; // [R7] [R8]
                    end
                end
                if (ev.level && st_q.edges != '0 && st_q.hiCnt == T_HD) begin
                    if (st_q.edges <= DATA_LIMIT) begin
                        writeStrobe = 1'b1; // [R9]
                    end
                    st_d.edges = '0; // [R8] [R10] [R12]
                    st_d.busy = 1'b0;
                    st_d.phase = S_ADDR;
                end
            end
            default: begin
                st_d.phase = S_OFF;
            end
        endcase
        // Any write goes to one of five; other addresses are silently dropped
        if (writeStrobe) begin // [R1]
            case (st_q.addr)
                REG_CURRENT: st_d.regs[0] = DW'(st_q.edges - ONE_C) & MASK_CURRENT;
                REG_ENABLE: st_d.regs[1] = DW'(st_q.edges - ONE_C) & MASK_ENABLE; // [R17]
                REG_REG1: st_d.regs[2] = DW'(st_q.edges - ONE_C) & MASK_REG1; // [R18]
                REG_REG2: st_d.regs[3] = DW'(st_q.edges - ONE_C) & MASK_REG2; // [R18]
                REG_RAMP: st_d.regs[4] = DW'(st_q.edges - ONE_C) & MASK_RAMP; // [R19]
                default: begin
                end
            endcase
        end
        if (st_q.phase != S_OFF && ev.level && st_q.hiCnt == T_SB) begin
            st_d.sb = 1'b1; // [R13]
            st_d.busy = 1'b0;
            st_d.held = 1'b0;
            st_d.edges = '0;
            st_d.phase = S_ADDR;
        end
        // Low too long: whole device drops back and forgets its settings
        if (!ev.level && st_q.loCnt >= T_SHUT) begin // [R3] [R20]
            st_d.phase = S_OFF;
            st_d.edges = '0;
            st_d.addr = '0;
            st_d.held = 1'b0;
            st_d.busy = 1'b0;
            st_d.regs = {5{RESET_VAL}};
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st_q.phase <= S_OFF;
            st_q.hiCnt <= '0;
            st_q.loCnt <= '0;
            st_q.edges <= '0;
            st_q.addr <= '0;
            st_q.held <= 1'b0;
            st_q.busy <= 1'b0;
            st_q.sb <= 1'b1;
            st_q.regs <= {5{RESET_VAL}}; // [R15]
        end else begin
            st_q <= st_d;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            deviceEnabled <= 1'b0;
            standby <= 1'b1;
            sinkCurrentCode <= '0;
            sinkEnableBits <= '0;
            regulator1VoltageCode <= '0;
            regulator2VoltageCode <= '0;
            rampRate <= '0;
            rampEnable <= 1'b0;
        end else begin
            deviceEnabled <= (st_d.phase != S_OFF);
            standby <= st_d.sb;
            sinkCurrentCode <= st_d.regs[0][4:0];
            sinkEnableBits <= st_d.regs[1][3:0];
            regulator1VoltageCode <= st_d.regs[2][3:0];
            regulator2VoltageCode <= st_d.regs[3][2:0];
            rampRate <= st_d.regs[4][2:1];
            rampEnable <= st_d.regs[4][0];
        end
    end

    property p_shutdown;
        @(posedge clock) disable iff (rst)
        (!ev.level && st_q.loCnt >= T_SHUT) |=> (!deviceEnabled && sinkCurrentCode == '0);
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("shutdown not applied"); // [R3]

    property p_clear_regs;
        @(posedge clock) disable iff (rst)
        (st_q.phase == S_OFF) |-> (st_q.regs == {5{RESET_VAL}});
    endproperty
    a_clear_regs: assert property (p_clear_regs) else $error("regs not cleared"); // [R20]

    property p_wake;
        @(posedge clock) disable iff (rst)
        (st_q.phase == S_OFF && ev.level && st_q.hiCnt >= T_WAKE) |=> deviceEnabled;
    endproperty
    a_wake: assert property (p_wake) else $error("wake missed"); // [R2]

    property p_data_write;
        @(posedge clock) disable iff (rst)
        (writeStrobe && st_q.addr == REG_RAMP) |=> (rampEnable == ($past(st_q.edges[0]) ^ 1'b1));
    endproperty
    a_data_write: assert property (p_data_write) else $error("ramp write wrong"); // [R9]

    property p_back_to_addr;
        @(posedge clock) disable iff (rst)
        writeStrobe |=> (st_q.phase == S_ADDR && st_q.edges == '0);
    endproperty
    a_back_to_addr: assert property (p_back_to_addr) else $error("not back to address"); // [R10]

    property p_overflow;
        @(posedge clock) disable iff (rst)
        (st_q.phase == S_DATA && st_q.edges > DATA_LIMIT) |-> !writeStrobe;
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow write"); // [R8]

    property p_addr_max;
        @(posedge clock) disable iff (rst)
        (st_q.phase == S_ADDR && st_q.held && ev.level && st_q.hiCnt == T_HAMAX
            && st_q.hiCnt != T_SB && st_q.loCnt < T_SHUT) |=> !st_q.held && st_q.edges == '0;
    endproperty
    a_addr_max: assert property (p_addr_max) else $error("address hold max ignored"); // [R6]

    property p_unused_bits;
        @(posedge clock) disable iff (rst)
        st_q.regs[3][5:3] == 3'h0 && st_q.regs[1][5:4] == 2'h0;
    endproperty
    a_unused_bits: assert property (p_unused_bits) else $error("unused bits set"); // [R17]

    // A fall at the maximum hold loses to the bus reset
    sequence s_addr_taken;
        st_q.phase == S_ADDR && st_q.held && ev.fall && st_q.hiCnt < T_HAMAX;
    endsequence

    property p_addr_latch;
        @(posedge clock) disable iff (rst)
        s_addr_taken |=> (st_q.phase == S_DATA && st_q.edges == '0
            && st_q.addr == AW'($past(st_q.edges) - ONE_C));
    endproperty
    a_addr_latch: assert property (p_addr_latch) else $error("address not latched"); // [R4]

    property p_addr_overflow;
        @(posedge clock) disable iff (rst)
        (st_q.phase == S_ADDR && st_q.busy && !st_q.held && ev.level
            && st_q.hiCnt == T_HAMIN && st_q.edges > ADDR_LIMIT)
            |=> (!st_q.busy && !st_q.held && st_q.edges == '0 && st_q.phase == S_ADDR);
    endproperty
    a_addr_overflow: assert property (p_addr_overflow) else $error("overflow kept"); // [R5]

    sequence s_data_hold;
        st_q.phase == S_DATA && ev.level && st_q.edges != '0 && st_q.hiCnt == T_HD;
    endsequence

    property p_data_done;
        @(posedge clock) disable iff (rst)
        s_data_hold |=> (st_q.phase == S_ADDR && !st_q.busy && st_q.edges == '0);
    endproperty
    a_data_done: assert property (p_data_done) else $error("data hold not closed"); // [R8]

    property p_current_store;
        @(posedge clock) disable iff (rst)
        (writeStrobe && st_q.addr == REG_CURRENT)
            |=> (sinkCurrentCode == 5'($past(st_q.edges) - ONE_C));
    endproperty
    a_current_store: assert property (p_current_store) else $error("current wrong"); // [R9]

    property p_enable_store;
        @(posedge clock) disable iff (rst)
        (writeStrobe && st_q.addr == REG_ENABLE)
            |=> (sinkEnableBits == 4'($past(st_q.edges) - ONE_C));
    endproperty
    a_enable_store: assert property (p_enable_store) else $error("enable wrong"); // [R17]

    property p_reg1_store;
        @(posedge clock) disable iff (rst)
        (writeStrobe && st_q.addr == REG_REG1)
            |=> (regulator1VoltageCode == 4'($past(st_q.edges) - ONE_C));
    endproperty
    a_reg1_store: assert property (p_reg1_store) else $error("reg1 wrong"); // [R18]

    property p_reg2_store;
        @(posedge clock) disable iff (rst)
        (writeStrobe && st_q.addr == REG_REG2)
            |=> (regulator2VoltageCode == 3'($past(st_q.edges) - ONE_C));
    endproperty
    a_reg2_store: assert property (p_reg2_store) else $error("reg2 wrong"); // [R18]

    property p_standby_enter;
        @(posedge clock) disable iff (rst)
        (st_q.phase != S_OFF && ev.level && st_q.hiCnt == T_SB)
            |=> (standby && st_q.phase == S_ADDR && st_q.edges == '0);
    endproperty
    a_standby_enter: assert property (p_standby_enter) else $error("standby missed"); // [R13]

    property p_standby_exit;
        @(posedge clock) disable iff (rst)
        (st_q.phase == S_ADDR && ev.rise && st_q.loCnt < T_SHUT) |=> !standby;
    endproperty
    a_standby_exit: assert property (p_standby_exit) else $error("standby kept"); // [R13]

    property p_enable_level;
        @(posedge clock) disable iff (rst)
        deviceEnabled == (st_q.phase != S_OFF);
    endproperty
    a_enable_level: assert property (p_enable_level) else $error("enable level wrong"); // [R2]
endmodule
`default_nettype wire

// ===== logic/pulse_pkg.sv
// Package: constants, state types and register layout for the pulse-count writer
// Assumes a single 20 MHz clock and a synchronous active-high reset
package pulse_pkg;
    localparam int CLK_HZ = 20000000;
    // Durations in microseconds as given or chosen
    localparam int WAKE_US = 100;
    localparam int SHUT_US = 2500;
    localparam int HOLDA_MIN_US = 500;
    localparam int HOLDA_MAX_US = 1000;
    localparam int HOLDD_US = 500;
    localparam int STANDBY_US = 10000;
    localparam int CYC_PER_US = CLK_HZ / 1000000;
    localparam int WAKE_CYC = WAKE_US * CYC_PER_US;
    localparam int SHUT_CYC = SHUT_US * CYC_PER_US;
    localparam int HOLDA_MIN_CYC = HOLDA_MIN_US * CYC_PER_US;
    localparam int HOLDA_MAX_CYC = HOLDA_MAX_US * CYC_PER_US;
    localparam int HOLDD_CYC = HOLDD_US * CYC_PER_US;
    localparam int STANDBY_CYC = STANDBY_US * CYC_PER_US;
    localparam int TW = 18;
    localparam int DW = 6;
    localparam int AW = 5;
    localparam int CW = 7;
    localparam logic [CW-1:0] ADDR_LIMIT = 7'h20;
    localparam logic [CW-1:0] DATA_LIMIT = 7'h40;
    localparam logic [AW-1:0] REG_CURRENT = 5'h00;
    localparam logic [AW-1:0] REG_ENABLE = 5'h01;
    localparam logic [AW-1:0] REG_REG1 = 5'h02;
    localparam logic [AW-1:0] REG_REG2 = 5'h03;
    localparam logic [AW-1:0] REG_RAMP = 5'h04;
    localparam logic [DW-1:0] RESET_VAL = 6'h00;
    localparam logic [DW-1:0] MASK_CURRENT = 6'h1F;
    localparam logic [DW-1:0] MASK_ENABLE = 6'h0F;
    localparam logic [DW-1:0] MASK_REG1 = 6'h0F;
    localparam logic [DW-1:0] MASK_REG2 = 6'h07;
    localparam logic [DW-1:0] MASK_RAMP = 6'h07;
    typedef enum logic [1:0] {
        S_OFF = 2'b00,
        S_ADDR = 2'b01,
        S_DATA = 2'b11
    } phase_t;
endpackage

// ===== logic/pulse_line_if.sv
// Interface: filtered line events from the sampler to the decoder
// Assumes both ends sit on the same clock
`timescale 1ns/100ps
`default_nettype none
interface pulse_line_if;
    logic level;
    logic rise;
    logic fall;
    modport src (output level, rise, fall);
    modport dst (input level, rise, fall);
endinterface
`default_nettype wire

// ===== logic/pulse_line_sync.sv
// Three-stage sampler for the pulse line with edge pulses
// Assumes the line is asynchronous to clock
`timescale 1ns/100ps
`default_nettype none
module pulse_line_sync (
    input wire logic clock,
    input wire logic rst,
    input wire logic pulseLine,
    pulse_line_if.src ev
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } sync_t;
    sync_t st_q, st_d;
    always_comb begin
        st_d = st_q;
        st_d.s1 = pulseLine;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        // Change counts only once stages two and three agree
        if (st_q.s2 == st_q.s3) begin
            st_d.lvl = st_q.s3;
        end
    end
    always_ff @(posedge clock) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    assign ev.level = st_q.lvl;
    assign ev.rise = (st_q.s2 == st_q.s3) && st_q.s3 && !st_q.lvl;
    assign ev.fall = (st_q.s2 == st_q.s3) && !st_q.s3 && st_q.lvl;
endmodule
`default_nettype wire

// ===== tb/pulse_host.sv
// Host model: drives the single pulse line with counted bursts and hold times
// Assumes the bench calls its tasks; the line only changes at falling clock edges
`timescale 1ns/100ps
`default_nettype none
module pulse_host (
    input wire logic clock,
    output var logic pulseLine
);
    // Line starts low so the device stays off until woken
    initial begin
        pulseLine = 1'b0;
    end

    task automatic drive(input logic lvl, input int cycles);
        repeat (cycles) begin
            @(negedge clock);
            pulseLine = lvl;
        end
    endtask

    // Widths of two cycles stay far below any hold time
    task automatic burst(input int edges);
        for (int i = 0; i < edges; i++) begin
            drive(1'b0, 2);
            drive(1'b1, 2);
        end
    endtask

    // Address always precedes its data; callers pass zero upper bits
    task automatic write(input int addr, input int value, input int aHold, input int dHold);
        burst(addr + 1);
        drive(1'b1, aHold);
        burst(value + 1);
        drive(1'b1, dHold);
    endtask
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the pulse-count register writer
// Assumes short hold thresholds so every scenario runs in a few thousand cycles
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import pulse_pkg::*;
    localparam int WAKE = 20;
    localparam int SHUT = 100;
    localparam int HMIN = 40;
    localparam int HMAX = 80;
    localparam int HDAT = 40;
    localparam int STBY = 400;
    localparam int HOLD = 50;
    logic clock;
    logic rst;
    wire pulseLine;
    logic deviceEnabled;
    logic standby;
    logic [4:0] sinkCurrentCode;
    logic [3:0] sinkEnableBits;
    logic [3:0] regulator1VoltageCode;
    logic [2:0] regulator2VoltageCode;
    logic [1:0] rampRate;
    logic rampEnable;
    logic [5:0] expReg [5];
    int failCount = 0;
    int nChecks = 0;

    pulse_host host (.clock(clock), .pulseLine(pulseLine));

    pulse_count_register_writer #(.WAKE_CYCLES(WAKE), .SHUT_CYCLES(SHUT),
        .HOLDA_MIN_CYCLES(HMIN), .HOLDA_MAX_CYCLES(HMAX), .HOLDD_CYCLES(HDAT),
        .STANDBY_CYCLES(STBY)) DUT (
        .clock(clock),
        .rst(rst),
        .pulseLine(pulseLine),
        .deviceEnabled(deviceEnabled),
        .standby(standby),
        .sinkCurrentCode(sinkCurrentCode),
        .sinkEnableBits(sinkEnableBits),
        .regulator1VoltageCode(regulator1VoltageCode),
        .regulator2VoltageCode(regulator2VoltageCode),
        .rampRate(rampRate),
        .rampEnable(rampEnable)
    );

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        nChecks++;
        if (seen !== exp) begin
            failCount++;
            $display("unexpected %s: expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic endSim;
        $display("checks %0d mismatches %0d", nChecks, failCount);
        if (failCount == 0 && nChecks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic checkAll;
        check("current", {3'h0, sinkCurrentCode}, {2'h0, expReg[0]});
        check("enable", {4'h0, sinkEnableBits}, {2'h0, expReg[1] & 6'h0F});
        check("reg1", {4'h0, regulator1VoltageCode}, {2'h0, expReg[2] & 6'h0F});
        check("reg2", {5'h00, regulator2VoltageCode}, {2'h0, expReg[3] & 6'h07});
        check("rate", {6'h00, rampRate}, {6'h00, expReg[4][2:1]});
        check("rampEn", {7'h00, rampEnable}, {7'h00, expReg[4][0]});
        check("enabled", {7'h00, deviceEnabled}, 8'h01);
    endtask

    task automatic doWrite(input int addr, input int value);
        host.write(addr, value, HOLD, HOLD);
        if (addr < 5) begin
            expReg[addr] = value[5:0];
        end
        checkAll();
    endtask

    // Wake-up: line low keeps device off, long high enables it
    task automatic wakeTest;
        int n;
        check("enabledOff", {7'h00, deviceEnabled}, 8'h00);
        check("standbyRst", {7'h00, standby}, 8'h01);
        host.drive(1'b1, WAKE + 5);
        n = 0;
        while (deviceEnabled !== 1'b1 && n < 20) begin
            @(negedge clock);
            n++;
        end
        if (n >= 20) begin
            failCount++;
            endSim();
        end else begin
            checkAll();
        end
    endtask

    // Every register, back to back with only the data hold between pairs
    task automatic mapTest;
        logic [5:0] vals [5];
        vals = '{6'h15, 6'h0A, 6'h0F, 6'h05, 6'h07};
        for (int a = 0; a < 5; a++) begin
            doWrite(a, vals[a]);
        end
        doWrite(0, 0);
        doWrite(31, 63);
    endtask

    // Too many address or data edges drop the write; next burst is an address
    task automatic overflowTest;
        host.burst(33);
        host.drive(1'b1, HOLD);
        doWrite(3, 2);
        host.burst(3);
        host.drive(1'b1, HOLD);
        host.burst(65);
        host.drive(1'b1, HOLD);
        checkAll();
        doWrite(2, 9);
    endtask

    // Address hold past its maximum resets the bus
    task automatic longHoldTest;
        host.burst(3);
        host.drive(1'b1, HMAX + 20);
        doWrite(1, 3);
    endtask

    task automatic standbyTest;
        check("standbyBusy", {7'h00, standby}, 8'h00);
        host.drive(1'b1, STBY + 20);
        check("standbyIdle", {7'h00, standby}, 8'h01);
        doWrite(4, 6);
    endtask

    // Long low disables and clears everything
    task automatic shutdownTest;
        host.drive(1'b0, SHUT + 20);
        check("enabledShut", {7'h00, deviceEnabled}, 8'h00);
        check("curShut", {3'h0, sinkCurrentCode}, 8'h00);
        check("enShut", {4'h0, sinkEnableBits}, 8'h00);
        check("reg1Shut", {4'h0, regulator1VoltageCode}, 8'h00);
        check("reg2Shut", {5'h00, regulator2VoltageCode}, 8'h00);
        check("rampShut", {5'h00, rampRate, rampEnable}, 8'h00);
        // Wake again: settings must come back at their defaults
        for (int i = 0; i < 5; i++) begin
            expReg[i] = 6'h00;
        end
        wakeTest();
    endtask

    initial begin
        repeat (100000) @(posedge clock);
        failCount++;
        endSim();
    end

    initial begin
        rst = 1'b1;
        for (int i = 0; i < 5; i++) begin
            expReg[i] = 6'h00;
        end
        repeat (16) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        wakeTest();
        mapTest();
        overflowTest();
        longHoldTest();
        standbyTest();
        shutdownTest();
        endSim();
    end
endmodule
`default_nettype wire
